/* File: rtl/dch_cmd_handler.v */
`timescale 1ns/1ns
`include "dch_map.vh"

module dch_cmd_handler #(
  parameter LOG_SECT_W = 2,
  parameter QUEUE_DEPTH = `DCH_QUEUE_DEPTH,
  parameter TAG_W = 5
) (
  input wire core_clk,
  input wire rst,
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [7:0] cmd_code,
  input wire [7:0] cmd_feature,
  input wire [7:0] cmd_count,
  input wire [15:0] cmd_lba,
  input wire [TAG_W-1:0] cmd_tag,
  input wire threshold_exceeded,
  input wire spindle_stopped,
  input wire media_error,
  output reg [7:0] status,
  output reg [7:0] error,
  output reg [7:0] cyl_low,
  output reg [7:0] cyl_high,
  output reg irq,
  output reg ncq_done,
  output reg [TAG_W-1:0] ncq_done_tag,
  output reg [1:0] ncq_fault,
  input wire host_wr_valid,
  input wire [7:0] host_wr_data,
  output reg host_wr_ready,
  output wire host_rd_valid,
  output wire [7:0] host_rd_data,
  input wire host_rd_ready,
  output reg media_wr_valid,
  output reg [7:0] media_wr_data,
  output reg media_wr_ecc,
  output reg [TAG_W-1:0] media_wr_tag,
  output reg spin_down_req,
  output reg standby_mode
);

  // ****************************************************************
  // Local constants
  // ****************************************************************
  localparam PTR_W = 18;
  localparam LOG_AW = LOG_SECT_W + 9;
  localparam LOG_SECTORS = 1 << LOG_SECT_W;
  localparam [8:0] LOG_SECT9 = LOG_SECTORS;
  localparam SBUF_BYTES = `DCH_SECTOR_BYTES + `DCH_ECC_BYTES;
  localparam [PTR_W-1:0] LEN_SECTOR = `DCH_SECTOR_BYTES;
  localparam [PTR_W-1:0] LEN_LONG = SBUF_BYTES;
  localparam [PTR_W-1:0] PTR_ONE = 1;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WR_IN = 3'h1;
  localparam [2:0] ST_RD_OUT = 3'h2;
  localparam [2:0] ST_MEDIA_WR = 3'h3;
  localparam [2:0] ST_LONG_OUT = 3'h4;

  localparam [3:0] CL_BAD = 4'h0;
  localparam [3:0] CL_RLOG = 4'h1;
  localparam [3:0] CL_STAT = 4'h2;
  localparam [3:0] CL_WLOG = 4'h3;
  localparam [3:0] CL_STANDBY = 4'h4;
  localparam [3:0] CL_WBUF = 4'h5;
  localparam [3:0] CL_RBUF = 4'h6;
  localparam [3:0] CL_WDMA = 4'h7;
  localparam [3:0] CL_QWR = 4'h8;
  localparam [3:0] CL_QRD = 4'h9;
  localparam [3:0] CL_WLONG = 4'hA;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  function [3:0] cmd_class;
    input [7:0] code;
    input [7:0] feat;
    begin
      case (code)
        `DCH_CMD_SMART: begin
          case (feat)
            `DCH_FEAT_READ_LOG: cmd_class = CL_RLOG;
            `DCH_FEAT_RET_STATUS: cmd_class = CL_STAT;
            `DCH_FEAT_WRITE_LOG: cmd_class = CL_WLOG;
            default: cmd_class = CL_BAD;
          endcase
        end
        `DCH_CMD_STANDBY: cmd_class = CL_STANDBY;
        `DCH_CMD_STANDBY_NOW: cmd_class = CL_STANDBY;
        `DCH_CMD_WRITE_BUF: cmd_class = CL_WBUF;
        `DCH_CMD_READ_BUF: cmd_class = CL_RBUF;
        `DCH_CMD_WRITE_DMA: cmd_class = CL_WDMA;
        `DCH_CMD_WRITE_DMA_EXT: cmd_class = CL_WDMA;
        `DCH_CMD_WRITE_QUEUED: cmd_class = CL_QWR;
        `DCH_CMD_READ_QUEUED: cmd_class = CL_QRD;
        `DCH_CMD_WRITE_LONG: cmd_class = CL_WLONG;
        default: cmd_class = CL_BAD;
      endcase
    end
  endfunction

  // Sector count to byte count, zero meaning 256 sectors
  function [PTR_W-1:0] byte_len;
    input [7:0] cnt;
    begin
      byte_len = {(cnt == 8'h00), cnt, 9'h000};
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg [2:0] state;
  reg [PTR_W-1:0] ptr;
  reg [PTR_W-1:0] xfer_len;
  reg cur_log;
  reg cur_long;
  reg cur_ncq;
  reg [TAG_W-1:0] cur_tag;
  reg [LOG_SECT_W-1:0] log_start;

  // Queue of host-tagged commands
  reg [QUEUE_DEPTH-1:0] q_pend;
  reg [QUEUE_DEPTH-1:0] q_wr;
  reg [15:0] q_lba [0:QUEUE_DEPTH-1];
  reg [7:0] q_cnt [0:QUEUE_DEPTH-1];

  // Log area and sector buffer
  reg [7:0] log_mem [0:LOG_SECTORS*`DCH_SECTOR_BYTES-1];
  reg [7:0] sbuf [0:SBUF_BYTES-1];

  wire [3:0] cls = cmd_class(cmd_code, cmd_feature);
  wire take_cmd = cmd_valid & cmd_ready;
  wire host_acc = host_wr_valid & host_wr_ready;
  wire xfer_last = (ptr == xfer_len - PTR_ONE);
  wire [8:0] log_end = {1'b0, cmd_lba[7:0]} + {1'b0, cmd_count};
  wire log_fit = (cmd_count != 8'h00) && (log_end <= LOG_SECT9);
  wire [LOG_AW-1:0] log_idx = {log_start, 9'h000} + ptr[LOG_AW-1:0];
  wire [9:0] sbuf_idx = ptr[9:0];
  wire [7:0] rd_byte = cur_log ? log_mem[log_idx] : sbuf[sbuf_idx];
  wire rd_push_ready;
  wire rd_push = (state == ST_RD_OUT) & rd_push_ready;

  // ****************************************************************
  // Queue service pick: lowest media address first
  // ****************************************************************
  reg pick_found;
  reg [TAG_W-1:0] pick_tag;
  reg [15:0] pick_lba;
  integer i;

  always @* begin
    pick_found = 1'b0;
    pick_tag = {TAG_W{1'b0}};
    pick_lba = 16'hFFFF;
    for (i = 0; i < QUEUE_DEPTH; i = i + 1) begin
      if (q_pend[i] && (!pick_found || q_lba[i] < pick_lba)) begin
        pick_found = 1'b1;
        pick_tag = i[TAG_W-1:0];
        pick_lba = q_lba[i];
      end
    end
  end

  // ****************************************************************
  // Buffer and log storage writes
  // ****************************************************************
  always @(posedge core_clk) begin
    if (state == ST_WR_IN && host_acc) begin
      if (cur_log) begin
        log_mem[log_idx] <= host_wr_data;
      end else begin
        sbuf[sbuf_idx] <= host_wr_data;
      end
    end
  end

  // Per-tag parameters captured at issue
  always @(posedge core_clk) begin
    if (take_cmd && (cls == CL_QWR || cls == CL_QRD) && !q_pend[cmd_tag]) begin
      q_lba[cmd_tag] <= cmd_lba;
      q_cnt[cmd_tag] <= cmd_count;
    end
  end

  // ****************************************************************
  // Read data leaves through a two-entry buffer
  // ****************************************************************
  dch_skid_buf #(
    .W(8)
  ) u_rd_buf (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(state == ST_RD_OUT),
    .in_data(rd_byte),
    .in_ready(rd_push_ready),
    .out_valid(host_rd_valid),
    .out_data(host_rd_data),
    .out_ready(host_rd_ready)
  );

  // ****************************************************************
  // Completion of a non-queued command, a queued write or a queue fault
  // ****************************************************************
  task finish;
    input fail;
    input fail_df;
    begin
      status <= fail ? (`DCH_ST_DRDY | `DCH_ST_ERR | (fail_df ? `DCH_ST_DF : 8'h00)) : `DCH_ST_DRDY;
      error <= fail ? `DCH_ERR_ABRT : 8'h00;
      irq <= 1'b1;
      state <= ST_IDLE;
      cmd_ready <= 1'b1;
      host_wr_ready <= 1'b0;
    end
  endtask

  // ****************************************************************
  // Main control
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      ptr <= {PTR_W{1'b0}};
      xfer_len <= {PTR_W{1'b0}};
      cur_log <= 1'b0;
      cur_long <= 1'b0;
      cur_ncq <= 1'b0;
      cur_tag <= {TAG_W{1'b0}};
      log_start <= {LOG_SECT_W{1'b0}};
      q_pend <= {QUEUE_DEPTH{1'b0}};
      q_wr <= {QUEUE_DEPTH{1'b0}};
      cmd_ready <= 1'b1;
      status <= `DCH_STATUS_RST;
      error <= `DCH_ERROR_RST;
      cyl_low <= 8'h00;
      cyl_high <= 8'h00;
      irq <= 1'b0;
      ncq_done <= 1'b0;
      ncq_done_tag <= {TAG_W{1'b0}};
      ncq_fault <= `DCH_FAULT_NONE;
      host_wr_ready <= 1'b0;
      media_wr_valid <= 1'b0;
      media_wr_data <= 8'h00;
      media_wr_ecc <= 1'b0;
      media_wr_tag <= {TAG_W{1'b0}};
      spin_down_req <= 1'b0;
      standby_mode <= 1'b0;
    end else begin
      irq <= 1'b0;
      ncq_done <= 1'b0;
      spin_down_req <= 1'b0;
      media_wr_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take_cmd) begin
            ptr <= {PTR_W{1'b0}};
            cur_long <= 1'b0;
            cur_ncq <= 1'b0;
            ncq_fault <= `DCH_FAULT_NONE;
            cmd_ready <= 1'b0;
            status <= `DCH_ST_BSY | `DCH_ST_DRDY;
            if (cls == CL_QWR || cls == CL_QRD) begin
              if (q_pend[cmd_tag]) begin
                q_pend <= {QUEUE_DEPTH{1'b0}};
                ncq_fault <= `DCH_FAULT_DUP_TAG;
                finish(1'b1, 1'b0);
              end else begin
                q_pend[cmd_tag] <= 1'b1;
                q_wr[cmd_tag] <= (cls == CL_QWR);
                standby_mode <= 1'b0;
                status <= `DCH_ST_DRDY;
                error <= 8'h00;
                cmd_ready <= 1'b1;
              end
            end else if (|q_pend) begin
              q_pend <= {QUEUE_DEPTH{1'b0}};
              ncq_fault <= `DCH_FAULT_OVERLAP;
              finish(1'b1, 1'b0);
            end else begin
              case (cls)
                CL_STAT: begin
                  cyl_low <= threshold_exceeded ? `DCH_SIG_BAD_LOW : `DCH_SIG_OK_LOW;
                  cyl_high <= threshold_exceeded ? `DCH_SIG_BAD_HIGH : `DCH_SIG_OK_HIGH;
                  finish(1'b0, 1'b0);
                end
                CL_RLOG, CL_WLOG: begin
                  if (!log_fit) begin
                    finish(1'b1, 1'b0);
                  end else begin
                    cur_log <= 1'b1;
                    log_start <= cmd_lba[LOG_SECT_W-1:0];
                    xfer_len <= byte_len(cmd_count);
                    if (cls == CL_RLOG) begin
                      state <= ST_RD_OUT;
                    end else begin
                      state <= ST_WR_IN;
                      host_wr_ready <= 1'b1;
                    end
                  end
                end
                CL_STANDBY: begin
                  standby_mode <= 1'b1;
                  spin_down_req <= !spindle_stopped;
                  finish(1'b0, 1'b0);
                end
                CL_WBUF: begin
                  cur_log <= 1'b0;
                  xfer_len <= LEN_SECTOR;
                  state <= ST_WR_IN;
                  host_wr_ready <= 1'b1;
                end
                CL_RBUF: begin
                  cur_log <= 1'b0;
                  xfer_len <= LEN_SECTOR;
                  state <= ST_RD_OUT;
                end
                CL_WDMA: begin
                  standby_mode <= 1'b0;
                  xfer_len <= byte_len(cmd_count);
                  media_wr_tag <= {TAG_W{1'b0}};
                  state <= ST_MEDIA_WR;
                  host_wr_ready <= 1'b1;
                end
                CL_WLONG: begin
                  standby_mode <= 1'b0;
                  cur_log <= 1'b0;
                  cur_long <= 1'b1;
                  xfer_len <= LEN_LONG;
                  state <= ST_WR_IN;
                  host_wr_ready <= 1'b1;
                end
                default: begin
                  finish(1'b1, 1'b0);
                end
              endcase
            end
          end else if (pick_found) begin
            if (q_wr[pick_tag]) begin
              cur_ncq <= 1'b1;
              cur_tag <= pick_tag;
              ptr <= {PTR_W{1'b0}};
              xfer_len <= byte_len(q_cnt[pick_tag]);
              media_wr_tag <= pick_tag;
              state <= ST_MEDIA_WR;
              cmd_ready <= 1'b0;
              host_wr_ready <= 1'b1;
            end else begin
              q_pend[pick_tag] <= 1'b0;
              ncq_done <= 1'b1;
              ncq_done_tag <= pick_tag;
              irq <= 1'b1;
            end
          end
        end
        ST_WR_IN: begin
          if (host_acc) begin
            ptr <= ptr + PTR_ONE;
            if (xfer_last) begin
              host_wr_ready <= 1'b0;
              if (cur_long) begin
                ptr <= {PTR_W{1'b0}};
                state <= ST_LONG_OUT;
              end else begin
                finish(1'b0, 1'b0);
              end
            end
          end
        end
        ST_RD_OUT: begin
          if (rd_push) begin
            ptr <= ptr + PTR_ONE;
            if (xfer_last) begin
              finish(1'b0, 1'b0);
            end
          end
        end
        ST_MEDIA_WR: begin
          if (media_error) begin
            if (cur_ncq) begin
              q_pend <= {QUEUE_DEPTH{1'b0}};
            end
            finish(1'b1, 1'b1);
          end else if (host_acc) begin
            media_wr_valid <= 1'b1;
            media_wr_data <= host_wr_data;
            media_wr_ecc <= 1'b0;
            ptr <= ptr + PTR_ONE;
            if (xfer_last) begin
              finish(1'b0, 1'b0);
              if (cur_ncq) begin
                q_pend[cur_tag] <= 1'b0;
                ncq_done <= 1'b1;
                ncq_done_tag <= cur_tag;
              end
            end
          end
        end
        ST_LONG_OUT: begin
          media_wr_valid <= 1'b1;
          media_wr_data <= sbuf[sbuf_idx];
          media_wr_ecc <= (ptr >= LEN_SECTOR);
          ptr <= ptr + PTR_ONE;
          if (xfer_last) begin
            finish(1'b0, 1'b0);
          end
        end
        default: begin
          state <= ST_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

endmodule

/* File: rtl/dch_map.vh */
`ifndef DCH_MAP_VH
`define DCH_MAP_VH

// ********************************
// Command codes and subcommand codes
// ********************************
`define DCH_CMD_SMART 8'hB0
`define DCH_FEAT_READ_LOG 8'hD5
`define DCH_FEAT_RET_STATUS 8'hDA
`define DCH_FEAT_WRITE_LOG 8'hD6
`define DCH_CMD_STANDBY 8'hE2
`define DCH_CMD_STANDBY_NOW 8'hE0
`define DCH_CMD_WRITE_BUF 8'hE8
`define DCH_CMD_READ_BUF 8'hE4
`define DCH_CMD_WRITE_DMA 8'hCA
`define DCH_CMD_WRITE_DMA_EXT 8'h35
`define DCH_CMD_WRITE_QUEUED 8'h61
`define DCH_CMD_READ_QUEUED 8'h60
`define DCH_CMD_WRITE_LONG 8'h32

// ********************************
// Reliability status signatures
// ********************************
`define DCH_SIG_OK_LOW 8'h4F
`define DCH_SIG_OK_HIGH 8'hC2
`define DCH_SIG_BAD_LOW 8'hF4
`define DCH_SIG_BAD_HIGH 8'h2C

// ********************************
// Status and error register layout, queue fault codes
// ********************************
`define DCH_ST_BSY 8'h80
`define DCH_ST_DRDY 8'h40
`define DCH_ST_DF 8'h20
`define DCH_ST_ERR 8'h01
`define DCH_ERR_ABRT 8'h04
`define DCH_STATUS_RST 8'h40
`define DCH_ERROR_RST 8'h00
`define DCH_FAULT_NONE 2'h0
`define DCH_FAULT_OVERLAP 2'h1
`define DCH_FAULT_DUP_TAG 2'h2

// ********************************
// Sizes
// ********************************
`define DCH_SECTOR_BYTES 512
`define DCH_ECC_BYTES 4
`define DCH_QUEUE_DEPTH 32

`endif

/* File: rtl/dch_skid_buf.v */
`timescale 1ns/1ns
`include "dch_map.vh"

module dch_skid_buf #(
  parameter W = 8
) (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  output reg out_valid,
  output reg [W-1:0] out_data,
  input wire out_ready
);

  reg [W-1:0] spare;
  reg [1:0] fill;
  reg [1:0] next_fill;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Occupancy after this edge
  always @* begin
    next_fill = fill;
    if (push && !pop) begin
      next_fill = fill + 2'h1;
    end else if (pop && !push) begin
      next_fill = fill - 2'h1;
    end
  end

  // Two-entry store, head word drives the output
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fill <= 2'h0;
      spare <= {W{1'b0}};
      out_data <= {W{1'b0}};
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      fill <= next_fill;
      out_valid <= (next_fill != 2'h0);
      in_ready <= (next_fill != 2'h2);
      if (push && !pop) begin
        if (fill == 2'h0) begin
          out_data <= in_data;
        end else begin
          spare <= in_data;
        end
      end else if (pop && !push) begin
        out_data <= spare;
      end else if (push && pop) begin
        if (fill == 2'h1) begin
          out_data <= in_data;
        end else begin
          out_data <= spare;
          spare <= in_data;
        end
      end
    end
  end

endmodule

/* File: verif/dch_cmd_handler_sva.sv */
`timescale 1ns/1ns
`include "dch_map.vh"

module dch_cmd_handler_sva (
  input logic core_clk,
  input logic rst,
  input logic cmd_valid,
  input logic cmd_ready,
  input logic [7:0] cmd_code,
  input logic [7:0] cmd_feature,
  input logic threshold_exceeded,
  input logic spindle_stopped,
  input logic media_error,
  input logic [7:0] status,
  input logic [7:0] error,
  input logic [7:0] cyl_low,
  input logic [7:0] cyl_high,
  input logic irq,
  input logic [1:0] ncq_fault,
  input logic host_wr_valid,
  input logic [7:0] host_wr_data,
  input logic host_wr_ready,
  input logic host_rd_valid,
  input logic [7:0] host_rd_data,
  input logic host_rd_ready,
  input logic media_wr_valid,
  input logic [7:0] media_wr_data,
  input logic spin_down_req,
  input logic standby_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  wire smart_st = take && cmd_code == `DCH_CMD_SMART && cmd_feature == `DCH_FEAT_RET_STATUS;
  wire stby = take && (cmd_code == `DCH_CMD_STANDBY || cmd_code == `DCH_CMD_STANDBY_NOW);
  logic dma_act;

  // ********************************
  // DMA write in progress
  // ********************************
  always @(posedge core_clk or posedge rst) begin
    if (rst)
      dma_act <= 1'b0;
    else if (take && (cmd_code == `DCH_CMD_WRITE_DMA || cmd_code == `DCH_CMD_WRITE_DMA_EXT))
      dma_act <= 1'b1;
    else if (irq)
      dma_act <= 1'b0;
  end

  a_sig_healthy: assert property (smart_st && !threshold_exceeded |=>
    irq && cyl_low == `DCH_SIG_OK_LOW && cyl_high == `DCH_SIG_OK_HIGH) else $error("healthy signature wrong");
  a_sig_exceeded: assert property (smart_st && threshold_exceeded |=>
    irq && cyl_low == `DCH_SIG_BAD_LOW && cyl_high == `DCH_SIG_BAD_HIGH) else $error("alarm signature wrong");
  a_standby_enter: assert property (stby |-> ##[1:3] standby_mode) else $error("standby not entered");
  a_spin_skip: assert property (stby && spindle_stopped |=> !spin_down_req [*3])
    else $error("spin-down on stopped spindle");
  a_unknown_abort: assert property (take && cmd_code == 8'h00 |=>
    irq && error == `DCH_ERR_ABRT && status[0]) else $error("unknown code not aborted");
  a_dma_stop: assert property (dma_act && media_error |-> ##[1:3]
    (irq && status == 8'h61 && error == `DCH_ERR_ABRT)) else $error("media fault not posted");
  a_dma_echo: assert property (dma_act && host_wr_valid && host_wr_ready && !media_error |=>
    media_wr_valid && media_wr_data == $past(host_wr_data)) else $error("media byte lost");
  a_rd_hold: assert property (host_rd_valid && !host_rd_ready |=>
    host_rd_valid && $stable(host_rd_data)) else $error("read byte dropped in stall");
  a_fault_abort: assert property ($rose(ncq_fault != 2'h0) |-> irq && error == `DCH_ERR_ABRT)
    else $error("queue fault without abort");
  c_status: cover property (smart_st ##1 irq);
  c_dma_err: cover property (dma_act && media_error);
  c_fault: cover property (ncq_fault == `DCH_FAULT_DUP_TAG);
endmodule

bind dch_cmd_handler dch_cmd_handler_sva u_sva (.*);

/* File: verif/dch_host_model.sv */
`timescale 1ns/1ns

// Host reader: takes device bytes, stalls one cycle in three
module dch_host_model (
  input logic core_clk,
  input logic rst,
  input logic stall,
  input logic host_rd_valid,
  input logic [7:0] host_rd_data,
  output logic host_rd_ready,
  output int rd_cnt
);
  logic [7:0] rd_mem [0:1023];
  logic [1:0] ph;

  // ********************************
  // Stall pattern and capture
  // ********************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph <= 2'h0;
      host_rd_ready <= 1'b0;
      rd_cnt <= 0;
    end else begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      host_rd_ready <= !(stall && ph == 2'h1);
      if (host_rd_valid && host_rd_ready) begin
        rd_mem[rd_cnt[9:0]] <= host_rd_data;
        rd_cnt <= rd_cnt + 1;
      end
    end
  end
endmodule

/* File: verif/tb_drive_command_handler.sv */
`timescale 1ns/1ns
`include "dch_map.vh"

module tb_drive_command_handler;
  logic core_clk = 0;
  logic rst = 1;
  logic cmd_valid = 0;
  logic [7:0] cmd_code = 8'h00, cmd_feature = 8'h00, cmd_count = 8'h00, host_wr_data = 8'h00;
  logic [15:0] cmd_lba = 16'h0000;
  logic [4:0] cmd_tag = 5'h00;
  logic threshold_exceeded = 0, spindle_stopped = 0, media_error = 0, host_wr_valid = 0, stall = 0;
  wire cmd_ready, irq, ncq_done, media_wr_valid, media_wr_ecc, spin_down_req, standby_mode;
  wire host_wr_ready, host_rd_valid, host_rd_ready;
  wire [7:0] status, error, cyl_low, cyl_high, host_rd_data, media_wr_data;
  wire [4:0] ncq_done_tag, media_wr_tag;
  wire [1:0] ncq_fault;
  int rd_cnt, miscompares = 0, total_checks = 0, cycles = 0;
  int irq_n = 0, med_n = 0, ecc_n = 0, spin_n = 0, done_n = 0;
  logic [7:0] med [0:1023];
  logic [31:0] done_mask = 0;
  logic wr_rdy, crdy;
  bit held = 0;

  always #5 core_clk = ~core_clk;

  dch_cmd_handler u_dut (.*);
  dch_host_model u_host (.*);

  // ********************************
  // Monitors, timeout and shared tasks
  // ********************************
  always @(negedge core_clk) begin
    wr_rdy = host_wr_ready;
    crdy = cmd_ready;
    if (irq === 1'b1) irq_n++;
    if (spin_down_req === 1'b1) spin_n++;
    if (ncq_done === 1'b1) begin
      done_mask[ncq_done_tag] = 1'b1;
      done_n++;
    end
    if (media_wr_valid === 1'b1) begin
      med[med_n[9:0]] = media_wr_data;
      med_n++;
      if (media_wr_ecc === 1'b1) ecc_n++;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t %s: saw %0h want %0h", $time, msg, seen, exp);
    end
  endtask

  function automatic logic [7:0] pat(input logic [7:0] s, input int i);
    return s + i[7:0] * 8'h0D;
  endfunction

  // Offer one command; hold keeps valid up for a back-to-back burst
  task automatic issue(input logic [7:0] c, f, n, input logic [15:0] a, input logic [4:0] t, input bit hold);
    if (!held) @(posedge core_clk);
    while (crdy !== 1'b1) @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_feature <= f;
    cmd_count <= n;
    cmd_lba <= a;
    cmd_tag <= t;
    do @(posedge core_clk); while (crdy !== 1'b1);
    held = hold;
    if (!hold) cmd_valid <= 1'b0;
  endtask

  task automatic wait_irq(input int k0, input int lim);
    repeat (lim) if (irq_n == k0) @(negedge core_clk);
    #1;
  endtask

  // Host bytes; e is the byte index where a media fault is injected
  task automatic send(input int n, input logic [7:0] s, input int e);
    int i;
    int k0;
    i = 0;
    k0 = irq_n;
    @(posedge core_clk);
    host_wr_valid <= 1'b1;
    host_wr_data <= s;
    while (i < n && irq_n == k0) begin
      @(posedge core_clk);
      media_error <= (i == e);
      if (wr_rdy === 1'b1) begin
        i++;
        host_wr_data <= pat(s, i);
      end
    end
    host_wr_valid <= 1'b0;
  endtask

  function automatic int errs(input int n, input logic [7:0] s, input int b);
    int e = 0;
    for (int i = 0; i < n; i++) if ((b < 0 ? med[i] : u_host.rd_mem[b + i]) !== pat(s, i)) e++;
    return e;
  endfunction

  // ********************************
  // Scenarios
  // ********************************
  task automatic t_status();
    for (int b = 0; b < 2; b++) begin
      @(posedge core_clk);
      threshold_exceeded <= b[0];
      issue(`DCH_CMD_SMART, `DCH_FEAT_RET_STATUS, 8'h01, 16'h0000, 5'h00, 0);
      wait_irq(irq_n, 5);
      check(cyl_low, b ? `DCH_SIG_BAD_LOW : `DCH_SIG_OK_LOW, "cyl low");
      check(cyl_high, b ? `DCH_SIG_BAD_HIGH : `DCH_SIG_OK_HIGH, "cyl high");
    end
    issue(8'h00, 8'h00, 8'h01, 16'h0000, 5'h00, 0);
    wait_irq(irq_n, 5);
    check(error, `DCH_ERR_ABRT, "unknown code");
    issue(`DCH_CMD_SMART, 8'h00, 8'h01, 16'h0000, 5'h00, 0);
    wait_irq(irq_n, 5);
    check(status & `DCH_ST_ERR, `DCH_ST_ERR, "unknown subcommand");
    $display("test status done");
  endtask

  task automatic t_standby();
    int s0;
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      spindle_stopped <= k[1];
      s0 = spin_n;
      issue(k[0] ? `DCH_CMD_STANDBY_NOW : `DCH_CMD_STANDBY, 8'h00, 8'h00, 16'h0000, 5'h00, 0);
      wait_irq(irq_n, 5);
      repeat (3) @(negedge core_clk);
      check(standby_mode, 1, "standby");
      check(spin_n - s0, k[1] ? 0 : 1, "spin-down");
    end
    $display("test standby done");
  endtask

  task automatic t_buf_log();
    int b;
    med_n = 0;
    issue(`DCH_CMD_WRITE_BUF, 8'h00, 8'h01, 16'h0000, 5'h00, 0);
    send(512, 8'h21, -1);
    wait_irq(irq_n, 8);
    check(med_n, 0, "buffer write reached media");
    b = rd_cnt;
    stall <= 1'b1;
    issue(`DCH_CMD_READ_BUF, 8'h00, 8'h01, 16'h0000, 5'h00, 0);
    repeat (1600) if (rd_cnt < b + 512) @(posedge core_clk);
    check(errs(512, 8'h21, b), 0, "buffer readback");
    issue(`DCH_CMD_SMART, `DCH_FEAT_WRITE_LOG, 8'h01, 16'h0003, 5'h00, 0);
    send(512, 8'h5A, -1);
    b = rd_cnt;
    issue(`DCH_CMD_SMART, `DCH_FEAT_READ_LOG, 8'h01, 16'h0003, 5'h00, 0);
    repeat (1600) if (rd_cnt < b + 512) @(posedge core_clk);
    check(errs(512, 8'h5A, b), 0, "log readback");
    stall <= 1'b0;
    issue(`DCH_CMD_SMART, `DCH_FEAT_READ_LOG, 8'h02, 16'h0003, 5'h00, 0);
    wait_irq(irq_n, 5);
    check(error, `DCH_ERR_ABRT, "log range");
    $display("test buffer and log done");
  endtask

  task automatic t_dma();
    int k0;
    for (int x = 0; x < 2; x++) begin
      med_n = 0;
      k0 = irq_n;
      issue(x ? `DCH_CMD_WRITE_DMA_EXT : `DCH_CMD_WRITE_DMA, 8'h00, 8'h01, 16'h0010, 5'h00, 0);
      send(512, 8'h07, x ? 20 : -1);
      wait_irq(k0, 8);
      repeat (4) @(negedge core_clk);
      check(irq_n - k0, 1, "dma interrupts");
      check(status, x ? 8'h61 : `DCH_ST_DRDY, "dma status");
      check(med_n, x ? 21 : 512, "dma media count");
      check(errs(x ? 20 : 512, 8'h07, -1), 0, "dma media data");
    end
    $display("test dma done");
  endtask

  task automatic t_long();
    int k0;
    med_n = 0;
    ecc_n = 0;
    k0 = irq_n;
    issue(`DCH_CMD_WRITE_LONG, 8'h00, 8'h01, 16'h0020, 5'h00, 0);
    send(516, 8'h33, -1);
    wait_irq(k0, 800);
    check(med_n, 516, "long write count");
    check(ecc_n, 4, "long write ecc");
    check(errs(516, 8'h33, -1), 0, "long write data");
    $display("test long write done");
  endtask

  task automatic t_queue();
    int k0;
    done_mask = 0;
    done_n = 0;
    for (int i = 0; i < 32; i++)
      issue(`DCH_CMD_READ_QUEUED, 8'h00, 8'h01, 16'd100 - i[15:0], i[4:0], i < 31);
    repeat (400) if (done_n < 32) @(posedge core_clk);
    check(done_mask, 32'hFFFFFFFF, "queue depth");
    check(ncq_fault, `DCH_FAULT_NONE, "queue fault");
    check(ncq_done_tag, 5'h00, "queue order");
    med_n = 0;
    issue(`DCH_CMD_WRITE_QUEUED, 8'h00, 8'h01, 16'h0030, 5'h05, 0);
    send(512, 8'h44, -1);
    wait_irq(irq_n, 8);
    check(med_n, 512, "queued write count");
    check(media_wr_tag, 5'h05, "queued write tag");
    issue(`DCH_CMD_READ_QUEUED, 8'h00, 8'h01, 16'h0040, 5'h01, 1);
    k0 = irq_n;
    issue(`DCH_CMD_WRITE_BUF, 8'h00, 8'h01, 16'h0000, 5'h00, 0);
    wait_irq(k0, 5);
    check(ncq_fault, `DCH_FAULT_OVERLAP, "overlap");
    issue(`DCH_CMD_READ_QUEUED, 8'h00, 8'h01, 16'h0050, 5'h07, 1);
    k0 = irq_n;
    issue(`DCH_CMD_READ_QUEUED, 8'h00, 8'h01, 16'h0060, 5'h07, 0);
    wait_irq(k0, 5);
    check(ncq_fault, `DCH_FAULT_DUP_TAG, "duplicate tag");
    check(error, `DCH_ERR_ABRT, "duplicate tag abort");
    $display("test queue done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_status();
    t_standby();
    t_buf_log();
    t_dma();
    t_long();
    t_queue();
    close_out();
  end
endmodule
